// ### rtl/qdrd_regs.sv
`timescale 1ns/1ps
// What this block does
// - frame is 24 bits: rw, zero, three target bits, three channel bits, 16 data.
// - channel codes 0-3 pick channels A-D, code 4 picks all four.
// - target code 000 is a function-register operation, not a channel access.
// - function code 000 is no operation; nothing changes.
// - function code 001 loads six config bits; upper data bits ignored.
// - ground adjust bit enables compensation; disabled by default.
// - pin direction one is output, zero input; input after reset.
// - output pins drive value bit; input pins report level, writes still stored in config.
// - serial-out disable bit turns the driver off; enabled by default.
// - function code 100 clears all outputs: midscale twos, lowest binary.
// - function code 101 copies all input registers to the dac registers.
// - target 010 stores 16 data bits into the selected channel code.
// - target 011 stores the low two data bits as channel range; a write of code 11 is dropped.
// - range 00 nominal default, 01 and 10 extended, 11 undefined.
// - target 100 stores six-bit twos complement gain trim, default zero.
// - gain trim spans -32 to +31 one-lsb steps.
// - target 101 stores eight-bit twos complement offset trim, default zero.
// - offset trim moves output in eighth-lsb steps, -16 to +15.875 lsb.
// - per-channel writes go to the channel from the shared decode.
module qdrd_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // write frame from the serial shifter
  input wire logic frame_valid,
  input wire logic [23:0] frame_data,
  // coding mode: high for twos complement
  input wire logic twos_comp,
  // digital port pins
  input wire logic gpio_pin_zero_i,
  output logic gpio_pin_zero_o,
  output logic gpio_pin_zero_oe,
  input wire logic gpio_pin_one_i,
  output logic gpio_pin_one_o,
  output logic gpio_pin_one_oe,
  // configuration outputs
  output logic gnd_adjust_en,
  output logic serial_out_en,
  output logic [5:0] config_readback,
  // per-channel state, channel A in the low slice
  output logic [63:0] input_code,
  output logic [63:0] dac_code,
  output logic [7:0] output_range,
  output logic [23:0] gain_trim,
  output logic [31:0] offset_trim
);
  // frame field split
  wire is_write = ~frame_data[qdrd_pkg::RW_POS] & ~frame_data[qdrd_pkg::ZERO_POS];
  wire wr = frame_valid & is_write;
  wire [2:0] tgt = frame_data[qdrd_pkg::TGT_HI:qdrd_pkg::TGT_LO];
  wire [2:0] chs = frame_data[qdrd_pkg::CH_HI:qdrd_pkg::CH_LO];
  wire [15:0] dat = frame_data[15:0];

  // shared channel decode
  wire all_ch = (chs == qdrd_pkg::CH_ALL);
  wire [3:0] ch_hit;
  assign ch_hit = all_ch ? 4'hF : ((chs[2] == 1'b0) ? (4'h1 << chs[1:0]) : 4'h0);

  // function-register decode
  wire fn_sel = wr & (tgt == qdrd_pkg::REG_FUNCTION);
  wire fn_cfg = fn_sel & (chs == qdrd_pkg::FN_CONFIG);
  wire fn_clr = fn_sel & (chs == qdrd_pkg::FN_CLEAR);
  wire fn_load = fn_sel & (chs == qdrd_pkg::FN_LOAD);
  // other function codes including no_operation fall through

  wire code_wr = wr & (tgt == qdrd_pkg::REG_CHANNEL_CODE);
  wire range_wr = wr & (tgt == qdrd_pkg::REG_OUTPUT_RANGE);
  wire gain_wr = wr & (tgt == qdrd_pkg::REG_GAIN_TRIM);
  wire offs_wr = wr & (tgt == qdrd_pkg::REG_OFFSET_TRIM);

  // both codings clear to stored code zero: 0 V in twos complement, lowest code in binary
  wire [15:0] clear_code = twos_comp ? qdrd_pkg::CLEAR_TWOS : qdrd_pkg::CLEAR_BIN;

  // pin synchronisers
  logic [1:0] pin0_sync_r;
  logic [1:0] pin1_sync_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin0_sync_r <= 2'h0;
      pin1_sync_r <= 2'h0;
    end else begin
      pin0_sync_r <= {pin0_sync_r[0], gpio_pin_zero_i};
      pin1_sync_r <= {pin1_sync_r[0], gpio_pin_one_i};
    end
  end

  // function configuration register
  logic [5:0] cfg_r;
  wire [5:0] cfg_nxt = fn_cfg ? dat[5:0] : cfg_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= qdrd_pkg::CONFIG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign gnd_adjust_en = cfg_r[qdrd_pkg::CFG_GND_ADJ];
  assign serial_out_en = ~cfg_r[qdrd_pkg::CFG_SER_OFF];
  assign gpio_pin_zero_oe = cfg_r[qdrd_pkg::CFG_PIN0_DIR];
  assign gpio_pin_one_oe = cfg_r[qdrd_pkg::CFG_PIN1_DIR];
  assign gpio_pin_zero_o = cfg_r[qdrd_pkg::CFG_PIN0_VAL];
  assign gpio_pin_one_o = cfg_r[qdrd_pkg::CFG_PIN1_VAL];
  // value bits of input pins read the synchronised level
  wire pin0_rb = gpio_pin_zero_oe ? cfg_r[qdrd_pkg::CFG_PIN0_VAL] : pin0_sync_r[1];
  wire pin1_rb = gpio_pin_one_oe ? cfg_r[qdrd_pkg::CFG_PIN1_VAL] : pin1_sync_r[1];
  assign config_readback = {cfg_r[5:4], pin1_rb, cfg_r[2], pin0_rb, cfg_r[0]};

  // per-channel registers: each channel keeps its own copy so no variable has two drivers
  genvar g;
  generate
    for (g = 0; g < qdrd_pkg::NUM_CH; g++) begin : g_ch
      logic [15:0] in_r;
      logic [15:0] dac_r;
      logic [1:0] rng_r;
      logic [5:0] gain_r;
      logic [7:0] offs_r;
      wire hit = ch_hit[g];
      // a clear overrides input codes too, so a later load cannot revive stale data
      wire [15:0] in_nxt = fn_clr ? clear_code : ((code_wr & hit) ? dat : in_r);
      wire [15:0] dac_nxt = fn_clr ? clear_code : (fn_load ? in_r : dac_r);
      // range code 11 is undefined, so such a write is dropped
      wire rng_ok = (dat[1:0] != qdrd_pkg::RANGE_UNDEF);
      wire [1:0] rng_nxt = (range_wr & hit & rng_ok) ? dat[1:0] : rng_r;
      wire [5:0] gain_nxt = (gain_wr & hit) ? dat[5:0] : gain_r;
      wire [7:0] offs_nxt = (offs_wr & hit) ? dat[7:0] : offs_r;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          in_r <= qdrd_pkg::CODE_RST;
        end else begin
          in_r <= in_nxt;
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          dac_r <= qdrd_pkg::CODE_RST;
        end else begin
          dac_r <= dac_nxt;
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          rng_r <= qdrd_pkg::RANGE_RST;
        end else begin
          rng_r <= rng_nxt;
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          gain_r <= qdrd_pkg::GAIN_RST;
        end else begin
          gain_r <= gain_nxt;
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          offs_r <= qdrd_pkg::OFFSET_RST;
        end else begin
          offs_r <= offs_nxt;
        end
      end
      assign input_code[16*g +: 16] = in_r;
      assign dac_code[16*g +: 16] = dac_r;
      assign output_range[2*g +: 2] = rng_r;
      assign gain_trim[6*g +: 6] = gain_r;
      assign offset_trim[8*g +: 8] = offs_r;
    end
  endgenerate

  // checks
  a_cfg_load: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_cfg |=> cfg_r == $past(dat[5:0]))
    else $error("config not loaded");
  a_noop_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fn_sel && chs == qdrd_pkg::FN_NO_OPERATION) |=> $stable(cfg_r) && $stable(dac_code)
    && $stable(input_code)) else $error("no-op changed state");
  a_clear_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_clr |=> dac_code == {4{$past(clear_code)}})
    else $error("clear failed");
  a_load_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_load |=> dac_code == $past(input_code))
    else $error("load failed");
  a_code_chan: assert property (
    @(posedge ref_clk) disable iff (rst)
    (code_wr && chs == 3'h2) |=> input_code[47:32] == $past(dat)
    && input_code[15:0] == $past(input_code[15:0])) else $error("code decode");
  a_code_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    (code_wr && all_ch) |=> input_code == {4{$past(dat)}})
    else $error("broadcast");
  a_range_low: assert property (
    @(posedge ref_clk) disable iff (rst)
    (range_wr && chs == 3'h1 && dat[1:0] != 2'h3) |=> output_range[3:2] == $past(dat[1:0]))
    else $error("range write");
  a_gain_wr: assert property (
    @(posedge ref_clk) disable iff (rst)
    (gain_wr && chs == 3'h3) |=> gain_trim[23:18] == $past(dat[5:0]))
    else $error("gain");
  a_offs_wr: assert property (
    @(posedge ref_clk) disable iff (rst)
    (offs_wr && chs == 3'h0) |=> offset_trim[7:0] == $past(dat[7:0]))
    else $error("offset");
  a_undef_tgt: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr && (tgt == 3'h1 || tgt[2:1] == 2'h3)) |=> $stable(input_code) && $stable(cfg_r)
    && $stable(gain_trim) && $stable(offset_trim)) else $error("undefined target");
  a_pin_drive: assert property (
    @(posedge ref_clk) disable iff (rst)
    gpio_pin_zero_oe |-> gpio_pin_zero_o == config_readback[1])
    else $error("pin0");
  a_code_other: assert property (
    @(posedge ref_clk) disable iff (rst)
    (code_wr && chs == 3'h1) |=> input_code[31:16] == $past(dat)
    && input_code[63:32] == $past(input_code[63:32])) else $error("code channel b");
  a_code_badch: assert property (
    @(posedge ref_clk) disable iff (rst)
    (code_wr && chs > qdrd_pkg::CH_ALL) |=> $stable(input_code))
    else $error("bad channel code");
  a_range_undef: assert property (
    @(posedge ref_clk) disable iff (rst)
    (range_wr && dat[1:0] == qdrd_pkg::RANGE_UNDEF) |=> $stable(output_range))
    else $error("undefined range stored");
  a_range_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    (range_wr && all_ch && dat[1:0] != 2'h3) |=> output_range == {4{$past(dat[1:0])}})
    else $error("range broadcast");
  a_gain_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    (gain_wr && all_ch) |=> gain_trim == {4{$past(dat[5:0])}})
    else $error("gain broadcast");
  a_offs_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    (offs_wr && all_ch) |=> offset_trim == {4{$past(dat[7:0])}})
    else $error("offset broadcast");
  a_offs_chan: assert property (
    @(posedge ref_clk) disable iff (rst)
    (offs_wr && chs == 3'h3) |=> offset_trim[31:24] == $past(dat[7:0])
    && offset_trim[23:0] == $past(offset_trim[23:0])) else $error("offset channel d");
  a_gain_chan: assert property (
    @(posedge ref_clk) disable iff (rst)
    (gain_wr && chs == 3'h0) |=> gain_trim[5:0] == $past(dat[5:0])
    && gain_trim[23:6] == $past(gain_trim[23:6])) else $error("gain channel a");
  a_clear_inputs: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_clr |=> input_code == {4{$past(clear_code)}})
    else $error("clear left input codes");
  a_clear_trims: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_clr |=> $stable(gain_trim) && $stable(offset_trim) && $stable(output_range))
    else $error("clear touched trims");
  a_load_keep: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_load |=> $stable(input_code))
    else $error("load changed input codes");
  a_dac_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(fn_clr || fn_load) |=> $stable(dac_code))
    else $error("dac code moved without load");
  a_cfg_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !fn_cfg |=> $stable(cfg_r))
    else $error("config moved without write");
  a_gnd_adj: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_cfg |=> gnd_adjust_en == $past(dat[5]))
    else $error("ground adjust");
  a_ser_drv: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_cfg |=> serial_out_en == !$past(dat[0]))
    else $error("serial out enable");
  a_pin_dir: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_cfg |=> gpio_pin_one_oe == $past(dat[4]) && gpio_pin_zero_oe == $past(dat[2]))
    else $error("pin direction");
  a_pin1_drive: assert property (
    @(posedge ref_clk) disable iff (rst)
    fn_cfg |=> gpio_pin_one_o == $past(dat[3]))
    else $error("pin1 value");
  a_noop_trims: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fn_sel && chs == qdrd_pkg::FN_NO_OPERATION) |=> $stable(gain_trim)
    && $stable(offset_trim) && $stable(output_range)) else $error("no-op changed trims");
  a_read_ignored: assert property (
    @(posedge ref_clk) disable iff (rst)
    (frame_valid && frame_data[qdrd_pkg::RW_POS]) |=> $stable(input_code) && $stable(cfg_r)
    && $stable(dac_code)) else $error("read frame wrote state");
  a_fn_undef: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fn_sel && (chs == 3'h2 || chs == 3'h3 || chs > 3'h5)) |=> $stable(cfg_r)
    && $stable(dac_code) && $stable(input_code)) else $error("undefined function acted");

  c_load: cover property (@(posedge ref_clk) disable iff (rst) code_wr ##[1:4] fn_load);
  c_clear: cover property (@(posedge ref_clk) disable iff (rst) fn_clr);
  c_cfg: cover property (@(posedge ref_clk) disable iff (rst) fn_cfg && dat[4]);
  c_bcast: cover property (@(posedge ref_clk) disable iff (rst) offs_wr && all_ch);
endmodule

// ### rtl/qdrd_pkg.sv
package qdrd_pkg;
  // 24-bit write frame layout
  localparam int FRAME_W = 24;
  localparam int RW_POS = 23;
  localparam int ZERO_POS = 22;
  localparam int TGT_HI = 21;
  localparam int TGT_LO = 19;
  localparam int CH_HI = 18;
  localparam int CH_LO = 16;
  localparam int NUM_CH = 4;
  // register-select offsets
  localparam logic [2:0] REG_FUNCTION = 3'h0;
  localparam logic [2:0] REG_CHANNEL_CODE = 3'h2;
  localparam logic [2:0] REG_OUTPUT_RANGE = 3'h3;
  localparam logic [2:0] REG_GAIN_TRIM = 3'h4;
  localparam logic [2:0] REG_OFFSET_TRIM = 3'h5;
  // function-register channel codes and the all-channel code
  localparam logic [2:0] FN_NO_OPERATION = 3'h0;
  localparam logic [2:0] FN_CONFIG = 3'h1;
  localparam logic [2:0] FN_CLEAR = 3'h4;
  localparam logic [2:0] FN_LOAD = 3'h5;
  localparam logic [2:0] CH_ALL = 3'h4;
  // config field positions
  localparam int CFG_GND_ADJ = 5;
  localparam int CFG_PIN1_DIR = 4;
  localparam int CFG_PIN1_VAL = 3;
  localparam int CFG_PIN0_DIR = 2;
  localparam int CFG_PIN0_VAL = 1;
  localparam int CFG_SER_OFF = 0;
  // reset, clear and undefined-range values
  localparam logic [5:0] CONFIG_RST = 6'h00;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic [5:0] GAIN_RST = 6'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [15:0] CLEAR_TWOS = 16'h0000;
  localparam logic [15:0] CLEAR_BIN = 16'h0000;
  localparam logic [1:0] RANGE_UNDEF = 2'h3;
endpackage

// ### verification/qdrd_host.sv
`timescale 1ns/1ps
module qdrd_host (
  // clock
  input wire logic ref_clk,
  // frames toward the register bank
  output logic frame_valid,
  output logic [23:0] frame_data
);
  initial begin
    frame_valid = 1'b0;
    frame_data = 24'hA5A5A5;
  end
  // frame bits are scrambled outside valid so stale data can never pass for a match
  task automatic send(input logic [23:0] f);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    frame_data <= f;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    frame_data <= ~f;
  endtask
  task automatic send_pair(input logic [23:0] a, input logic [23:0] b);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    frame_data <= a;
    @(posedge ref_clk);
    frame_data <= b;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    frame_data <= ~b;
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [23:0] frame; logic [2:0] sel; logic [63:0] exp;} qdrd_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic twos = 1'b1;
  logic frame_valid, p0_o, p0_oe, p1_o, p1_oe, gnd_en, ser_en;
  logic [23:0] frame_data, gain;
  logic [5:0] cfg_rb;
  logic [63:0] in_code, dac;
  logic [7:0] rng;
  logic [31:0] offs;
  int errors = 0;
  int checks = 0;
  qdrd_row_t rows [18];
  always #2.5 ref_clk = ~ref_clk;
  qdrd_host host (.ref_clk(ref_clk), .frame_valid(frame_valid), .frame_data(frame_data));
  // both codings clear to stored code zero; each coding is exercised once
  qdrd_regs uut (.ref_clk(ref_clk), .rst(rst), .frame_valid(frame_valid),
    .frame_data(frame_data), .twos_comp(twos), .gpio_pin_zero_i(1'b1),
    .gpio_pin_zero_o(p0_o), .gpio_pin_zero_oe(p0_oe), .gpio_pin_one_i(1'b0),
    .gpio_pin_one_o(p1_o), .gpio_pin_one_oe(p1_oe), .gnd_adjust_en(gnd_en),
    .serial_out_en(ser_en), .config_readback(cfg_rb), .input_code(in_code),
    .dac_code(dac), .output_range(rng), .gain_trim(gain), .offset_trim(offs));
  function automatic logic [63:0] pick(input logic [2:0] s);
    case (s)
      3'h0: return in_code;
      3'h1: return dac;
      3'h2: return {56'h0, rng};
      3'h3: return {40'h0, gain};
      3'h4: return {32'h0, offs};
      3'h5: return {58'h0, cfg_rb};
      default: return {58'h0, p1_oe, p1_o, p0_oe, p0_o, gnd_en, ser_en};
    endcase
  endfunction
  task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
  initial begin
    rows = '{'{24'h12ABCD, 3'h0, 64'hABCD00000000}, '{24'h050000, 3'h1, 64'hABCD00000000},
      '{24'h14FFFF, 3'h0, 64'hFFFFFFFFFFFFFFFF}, '{24'h000000, 3'h1, 64'hABCD00000000},
      '{24'h1B0002, 3'h2, 64'h80}, '{24'h180003, 3'h2, 64'h80}, '{24'h21FFE0, 3'h3, 64'h800},
      '{24'h2A007F, 3'h4, 64'h7F0000}, '{24'h2D0080, 3'h4, 64'h7F0000},
      '{24'h3C1234, 3'h0, 64'hFFFFFFFFFFFFFFFF}, '{24'h521111, 3'h0, 64'hFFFFFFFFFFFFFFFF},
      '{24'h921111, 3'h0, 64'hFFFFFFFFFFFFFFFF}, '{24'h01FFC1, 3'h5, 64'h03},
      '{24'h01FFC1, 3'h6, 64'h00}, '{24'h01003E, 3'h6, 64'h3F}, '{24'h01003E, 3'h5, 64'h3E},
      '{24'h021234, 3'h5, 64'h3E}, '{24'h04FFFF, 3'h1, 64'h0}};
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1 check("reset state", pick(3'h6) | in_code | dac | rng | gain | offs, 64'h01);
    // rows cover plain writes, ignored frames, config bits, clear and load
    foreach (rows[i]) begin
      host.send(rows[i].frame);
      #1 check("row output", pick(rows[i].sel), rows[i].exp);
    end
    host.send_pair(24'h111234, 24'h050000);
    #1 check("back to back load", dac, 64'h12340000);
    @(posedge ref_clk);
    twos <= 1'b0;
    host.send(24'h04FFFF);
    #1 check("binary clear", dac, 64'h0);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    #1 check("mid-run reset", pick(3'h6) | in_code | dac | {58'h0, cfg_rb}, 64'h01);
    @(posedge ref_clk);
    rst <= 1'b0;
    host.send(24'h100005);
    #1 check("write after reset", in_code, 64'h5);
    check("pin level after reset", {58'h0, cfg_rb}, 64'h02);
    print_verdict();
  end
endmodule
